/* logic/rtc_calendar_alarm_value_regs.sv */
// Purpose: Calendar and alarm value windows behind a write unlock.
// Assumes: Single clock, strobes one cycle long.
// Notes: Read data valid the cycle after the read strobe.
// Notes: Window digits are stored as written; ranges are not checked.
// Notes: The control word stays writable so software can always unlock.
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module rtc_calendar_alarm_value_regs (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [rtc_value_pkg::ADDR_W-1:0] addr,
  input wire logic [rtc_value_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [rtc_value_pkg::DATA_W-1:0] rdata,
  output logic clock_write_unlock,
  output logic [1:0] calendar_window_pointer,
  output logic [1:0] alarm_window_pointer
);
  import rtc_value_pkg::*;

  typedef struct packed {
    logic unlock;
    logic [1:0] cal_ptr;
    logic [1:0] alm_ptr;
    logic [7:0] year;
    logic [12:0] cal_md;
    logic [12:0] alm_md;
    logic [10:0] alm_wh;
    logic [15:0] rdata;
  } state_t;

  state_t s;
  state_t next_s;

  // ==========================================
  // Bus decode
  // Each strobe is qualified by its address in one place.
  logic hit_control;
  logic hit_cal_window;
  logic hit_alm_window;
  logic hit_unmapped;

  logic write_control;
  logic write_cal_window;
  logic write_alm_window;

  logic read_control;
  logic read_cal_window;
  logic read_alm_window;
  logic window_write_allowed;

  assign hit_control = (addr == OFS_CONTROL);
  assign hit_cal_window = (addr == OFS_CAL_WINDOW);
  assign hit_alm_window = (addr == OFS_ALM_WINDOW);
  assign hit_unmapped = !(hit_control || hit_cal_window || hit_alm_window);

  assign write_control = wr && hit_control;
  assign write_cal_window = wr && hit_cal_window;
  assign write_alm_window = wr && hit_alm_window;

  assign read_control = rd && hit_control;
  assign read_cal_window = rd && hit_cal_window;
  assign read_alm_window = rd && hit_alm_window;
  assign window_write_allowed = s.unlock; // R6

  // ==========================================
  // Pointer decode
  // Each decoded pointer code names one register behind its window; the other codes name none.
  logic cal_sel_month_day;
  logic cal_sel_year;
  logic alm_sel_month_day;
  logic alm_sel_weekday_hour;

  assign cal_sel_month_day = (s.cal_ptr == PTR_MONTH_DAY); // R12
  assign cal_sel_year = (s.cal_ptr == PTR_YEAR); // R12
  assign alm_sel_month_day = (s.alm_ptr == PTR_MONTH_DAY); // R7
  assign alm_sel_weekday_hour = (s.alm_ptr == PTR_WEEKDAY_HOUR); // R8

  // ==========================================
  // Write enables
  // A window write lands only while unlocked and only in a decoded register.
  logic load_cal_md;
  logic load_year;
  logic load_alm_md;
  logic load_alm_wh;

  assign load_cal_md = write_cal_window && window_write_allowed && cal_sel_month_day; // R13
  assign load_year = write_cal_window && window_write_allowed && cal_sel_year; // R13
  assign load_alm_md = write_alm_window && window_write_allowed && alm_sel_month_day; // R13
  assign load_alm_wh = write_alm_window && window_write_allowed && alm_sel_weekday_hour; // R13

  // ==========================================
  // Field packing
  // Unused bit positions are never stored and always read as zero.

  // Places the stored month and day digits in their register positions.
  function automatic logic [15:0] md_word(input logic [12:0] v);
    logic [15:0] w;
    w = 16'h0000;
    w[POS_MONTH_TENS] = v[12]; // R1
    w[POS_MONTH_ONES +: 4] = v[11:8]; // R2
    w[POS_DAY_TENS +: 2] = v[5:4]; // R3
    w[POS_DAY_ONES +: 4] = v[3:0]; // R4
    return w;
  endfunction

  // Keeps only the month and day digit bits of a written word.
  function automatic logic [12:0] md_field(input logic [15:0] w);
    logic [12:0] v;
    v = 13'h0;
    v[12] = w[POS_MONTH_TENS]; // R1
    v[11:8] = w[POS_MONTH_ONES +: 4]; // R2
    v[5:4] = w[POS_DAY_TENS +: 2]; // R3
    v[3:0] = w[POS_DAY_ONES +: 4]; // R4
    return v;
  endfunction

  // Places the stored weekday and hour digits in their register positions.
  function automatic logic [15:0] wh_word(input logic [10:0] v);
    logic [15:0] w;
    w = 16'h0000;
    w[POS_WEEKDAY +: 3] = v[10:8]; // R9
    w[POS_DAY_TENS +: 2] = v[5:4]; // R10
    w[POS_DAY_ONES +: 4] = v[3:0]; // R11
    return w;
  endfunction

  // Keeps only the weekday and hour digit bits of a written word.
  function automatic logic [10:0] wh_field(input logic [15:0] w);
    logic [10:0] v;
    v = 11'h0;
    v[10:8] = w[POS_WEEKDAY +: 3]; // R9
    v[5:4] = w[POS_DAY_TENS +: 2]; // R10
    v[3:0] = w[POS_DAY_ONES +: 4]; // R11
    return v;
  endfunction

  // Places the stored year digits in the low byte.
  function automatic logic [15:0] year_word(input logic [7:0] v);
    logic [15:0] w;
    w = 16'h0000;
    w[POS_YEAR_TENS +: 4] = v[7:4]; // R12
    w[3:0] = v[3:0]; // R12
    return w;
  endfunction

  // Keeps only the year digits of a written word.
  function automatic logic [7:0] year_field(input logic [15:0] w);
    logic [7:0] v;
    v = 8'h00;
    v[7:4] = w[POS_YEAR_TENS +: 4]; // R12
    v[3:0] = w[3:0]; // R12
    return v;
  endfunction

  // ==========================================
  // Control register
  // Unlock and pointers share one word that is always writable.

  // Packs the unlock bit and both pointers into the control word.
  function automatic logic [15:0] ctl_word(
    input logic unlock,
    input logic [1:0] cal_ptr,
    input logic [1:0] alm_ptr
  );
    logic [15:0] w;
    w = 16'h0000;
    w[POS_UNLOCK] = unlock;
    w[POS_CAL_PTR +: 2] = cal_ptr;
    w[POS_ALM_PTR +: 2] = alm_ptr;
    return w;
  endfunction

  // Takes the unlock bit from a written control word.
  function automatic logic ctl_unlock(input logic [15:0] w);
    logic v;
    v = w[POS_UNLOCK];
    return v;
  endfunction

  // Takes the calendar pointer from a written control word.
  function automatic logic [1:0] ctl_cal_ptr(input logic [15:0] w);
    logic [1:0] v;
    v = w[POS_CAL_PTR +: 2];
    return v;
  endfunction

  // Takes the alarm pointer from a written control word.
  function automatic logic [1:0] ctl_alm_ptr(input logic [15:0] w);
    logic [1:0] v;
    v = w[POS_ALM_PTR +: 2];
    return v;
  endfunction

  // ==========================================
  // Window views
  // Pointer codes without a register read as zero.

  // Presents the register that the calendar pointer selects.
  function automatic logic [15:0] cal_read(
    input logic [1:0] ptr,
    input logic [12:0] md,
    input logic [7:0] yr
  );
    logic [15:0] w;
    w = 16'h0000;
    unique case (ptr)
      PTR_MONTH_DAY: begin
        w = md_word(md); // R12
      end
      PTR_YEAR: begin
        w = year_word(yr); // R12
      end
      default: begin
        w = 16'h0000; // R5
      end
    endcase
    return w;
  endfunction

  // Presents the register that the alarm pointer selects.
  function automatic logic [15:0] alm_read(
    input logic [1:0] ptr,
    input logic [12:0] md,
    input logic [10:0] wh
  );
    logic [15:0] w;
    w = 16'h0000;
    unique case (ptr)
      PTR_MONTH_DAY: begin
        w = md_word(md); // R7
      end
      PTR_WEEKDAY_HOUR: begin
        w = wh_word(wh); // R8
      end
      default: begin
        w = 16'h0000; // R5
      end
    endcase
    return w;
  endfunction

  // ==========================================
  // Next state
  // Read data stand for one cycle and are zero otherwise.
  always_comb begin
    logic [15:0] read_word;
    next_s = s;
    read_word = 16'h0000;
    // The control word is taken whatever the unlock state.
    if (write_control) begin
      next_s.unlock = ctl_unlock(wdata);
      next_s.cal_ptr = ctl_cal_ptr(wdata);
      next_s.alm_ptr = ctl_alm_ptr(wdata);
    end
    if (load_cal_md) begin
      next_s.cal_md = md_field(wdata); // R6 R12
    end
    if (load_year) begin
      next_s.year = year_field(wdata); // R6 R12
    end
    if (load_alm_md) begin
      next_s.alm_md = md_field(wdata); // R6 R7
    end
    if (load_alm_wh) begin
      next_s.alm_wh = wh_field(wdata); // R6 R8
    end
    if (read_control) begin
      read_word = ctl_word(s.unlock, s.cal_ptr, s.alm_ptr);
    end else if (read_cal_window) begin
      read_word = cal_read(s.cal_ptr, s.cal_md, s.year);
    end else if (read_alm_window) begin
      read_word = alm_read(s.alm_ptr, s.alm_md, s.alm_wh);
    end else if (rd && hit_unmapped) begin
      read_word = 16'h0000; // R5
    end else begin
      read_word = 16'h0000;
    end
    next_s.rdata = read_word;
  end

  // ==========================================
  // State register
  // Every stored value starts from zero.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s.unlock <= 1'b0;
      s.cal_ptr <= RESET_PTR;
      s.alm_ptr <= RESET_PTR;
      s.year <= 8'h00;
      s.cal_md <= 13'h0;
      s.alm_md <= 13'h0;
      s.alm_wh <= 11'h0;
      s.rdata <= RESET_VALUE;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================
  // Outputs
  // All outputs come straight from the state register.
  assign rdata = s.rdata;
  assign clock_write_unlock = s.unlock;
  assign calendar_window_pointer = s.cal_ptr;
  assign alarm_window_pointer = s.alm_ptr;
endmodule

/* logic/rtc_value_pkg.sv */
// Purpose: Constants for the calendar and alarm value windows.
// Assumes: 16-bit register port, one word per offset.
// Notes: Offsets are local choices.
// Function
// R1 - Month tens digit is bit 12.
// R2 - Month ones digit in bits 11-8.
// R3 - Day tens digit in bits 5-4.
// R4 - Day ones digit in bits 3-0.
// R5 - Unused value bits read as zero.
// R6 - Value writes accepted only while unlocked.
// R7 - Alarm pointer 10 selects alarm month/day.
// R8 - Alarm pointer 01 selects alarm weekday/hour.
// R9 - Alarm weekday in bits 10-8.
// R10 - Alarm hour tens in bits 5-4.
// R11 - Alarm hour ones in bits 3-0.
// R12 - Calendar pointer 10 month/day, 11 year.
// R13 - Locked write changes nothing at all; here a locked control word write still lands.
package rtc_value_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_CAL_WINDOW = 4'h1;
  localparam logic [3:0] OFS_ALM_WINDOW = 4'h2;
  localparam int POS_UNLOCK = 0;
  localparam int POS_CAL_PTR = 8;
  localparam int POS_ALM_PTR = 12;
  localparam logic [1:0] PTR_WEEKDAY_HOUR = 2'h1;
  localparam logic [1:0] PTR_MONTH_DAY = 2'h2;
  localparam logic [1:0] PTR_YEAR = 2'h3;
  localparam int POS_MONTH_TENS = 12;
  localparam int POS_MONTH_ONES = 8;
  localparam int POS_WEEKDAY = 8;
  localparam int POS_DAY_TENS = 4;
  localparam int POS_DAY_ONES = 0;
  localparam int POS_YEAR_TENS = 4;
  localparam logic [1:0] RESET_PTR = 2'h0;
  localparam logic [15:0] RESET_VALUE = 16'h0000;
endpackage

/* verification/rtc_value_monitor.sv */
// Purpose: Port checks for the value windows.
// Assumes: Offsets 0 to 2, read data one cycle late.
// Notes: Bound to the top module.
`timescale 1ns/1ps
module rtc_value_monitor(input wire logic clk,nrst,wr,rd,input wire logic [3:0] addr,
  input wire logic [15:0] wdata,rdata,input wire logic clock_write_unlock,
  input wire logic [1:0] calendar_window_pointer,alarm_window_pointer);
  wire u=clock_write_unlock;
  wire [1:0] c=calendar_window_pointer,m=alarm_window_pointer;
  default clocking @(posedge clk);endclocking
  default disable iff(!nrst);
  property p_cmd;wr&&addr==1&&u&&c==2 ##1 rd&&addr==1|=>rdata==($past(wdata,2)&16'h1F3F);
  endproperty
  a_cmd: assert property(p_cmd) else $error("cal month day");
  property p_amd;wr&&addr==2&&u&&m==2 ##1 rd&&addr==2|=>rdata==($past(wdata,2)&16'h1F3F);
  endproperty
  a_amd: assert property(p_amd) else $error("alarm month day");
  property p_awh;wr&&addr==2&&u&&m==1 ##1 rd&&addr==2|=>rdata==($past(wdata,2)&16'h073F);
  endproperty
  a_awh: assert property(p_awh) else $error("alarm weekday hour");
  property p_ctl;$past(wr&&addr==0)|->{m,c,u}=={$past(wdata[13:12]),$past(wdata[9:8]),$past(wdata[0])};
  endproperty
  a_ctl: assert property(p_ctl) else $error("control");
  property p_hold;!$past(wr&&addr==0)|->$stable({m,c,u});endproperty
  a_hold: assert property(p_hold) else $error("control hold");
  property p_idle;!$past(rd)|->rdata==0;endproperty
  a_idle: assert property(p_idle) else $error("idle data");
  property p_unm;$past(rd&&addr>2)|->rdata==0;endproperty
  a_unm: assert property(p_unm) else $error("unmapped");
  property p_wpad;$past(rd&&addr==2&&m==1)|->rdata[15:11]==0&&rdata[7:6]==0;endproperty
  a_wpad: assert property(p_wpad) else $error("weekday pad");
endmodule
bind rtc_calendar_alarm_value_regs rtc_value_monitor i_mon(.*);

/* verification/tb.sv */
// Purpose: Bench for the value windows.
// Assumes: Offsets 0 to 2.
// Notes: Random window data.
`timescale 1ns/1ps
module tb;
  import rtc_value_pkg::*;
  logic clk=0,nrst=0,wr=0,rd=0,p=0;
  logic [3:0] addr=0;
  logic [15:0] wdata=0,rdata,d,e,q[$];
  int mismatches=0,checked=0;
  rtc_calendar_alarm_value_regs i_dut(.clk,.nrst,.addr,.wdata,.wr,.rd,.rdata,
    .clock_write_unlock(),.calendar_window_pointer(),.alarm_window_pointer());
  initial forever #10 clk=~clk;
  task tally_and_finish;
    $display("checked %0d mismatches %0d",checked,mismatches);
    if(mismatches==0&&checked>0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [15:0] s,x);
    checked++;
    if(s!==x) begin
      mismatches++;
      $display("BAD rdata exp %h seen %h",x,s);
    end
  endtask
  task b(input logic w,r,input logic [3:0] a,input logic [15:0] v,x);
    wr<=w;rd<=r;addr<=a;wdata<=v;
    if(r) q.push_back(x);
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    if(p) chk(rdata,q.pop_front());
    p<=rd;
  end
  initial begin
    void'($urandom(30109));
    repeat(10) @(posedge clk);
    nrst<=1;
    b(0,1,0,0,0);
    repeat(6) begin
      d=$urandom;e=$urandom;
      b(1,0,0,16'h2201,0);b(1,0,1,d,0);b(0,1,1,0,d&16'h1F3F);b(1,0,2,e,0);
      b(0,1,2,0,e&16'h1F3F);b(1,0,0,16'h2200,0);b(1,0,1,~d,0);b(1,0,2,~e,0);
      b(0,1,1,0,d&16'h1F3F);b(0,1,2,0,e&16'h1F3F);b(0,1,0,0,16'h2200);
      b(1,0,0,16'h1001,0);b(1,0,2,e,0);b(0,1,2,0,e&16'h073F);b(0,1,4'hF,0,0);
      b(1,0,0,16'h0301,0);b(1,0,1,d,0);b(0,1,1,0,d&16'h00FF);b(1,0,0,16'h0300,0);
      b(1,0,1,~d,0);b(0,1,1,0,d&16'h00FF);b(1,0,0,16'h0001,0);b(1,0,1,e,0);b(0,1,1,0,0);
    end
    b(0,0,0,0,0);
    @(posedge clk);
    tally_and_finish;
  end
endmodule
